// file: flc_consts.svh
/*
 Offsets, field positions, reset values and key codes of the flash control block.
 Assumes it is included by bare name from the package and the two ends.
// Function
// - Illegal flash or register access sets violation flag
// - Enabled violation flag raises non-maskable request
// - Violation flag stays set until software clears
// - Wrong key sets key flag, requests reset
// - Upper byte reads 96h; writes need A5h
// - Block write needs write enable also set
// - Emergency exit clears mode register write/erase bits
// - Mass-erase and erase bits encode erase type
// - Reserved bits always read as zero
// - Source field picks auxiliary, main, sub-main clock
// - Divider field divides clock by value plus one
// - Lock during write or erase never aborts
// - Lock in block wait ends block mode
// - Wait bit shows readiness for next block word
// - Busy bit mirrors timing generator activity
// - Key flag stays set until software clears
// - Clock register write while busy is violation
// - Flash write without write enable is violation
// - Emergency exit stops operation, returns to read
// - Mode register write while operating is violation
*/
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH
`define FLC_ADDR_IRQ_EN   16'h0000
`define FLC_ADDR_MODE     16'h0128
`define FLC_ADDR_CLOCK    16'h012A
`define FLC_ADDR_STATUS   16'h012C
`define FLC_KEY_WRITE     8'hA5
`define FLC_KEY_READ      8'h96
`define FLC_RST_MODE      16'h9600
`define FLC_RST_CLOCK     16'h9642
`define FLC_RST_STATUS    16'h9618
`define FLC_LOOP_OPCODE   16'h3FFF
`define FLC_B_BLK         7
`define FLC_B_WRITE_EN    6
`define FLC_B_MASS_ERASE  2
`define FLC_B_ERASE       1
`define FLC_B_EXIT        5
`define FLC_B_LOCK        4
`define FLC_B_WAIT        3
`define FLC_B_ACCV        2
`define FLC_B_KEY_FLAG    1
`define FLC_B_BUSY        0
`define FLC_B_ACCV_IRQ_EN 5
`define FLC_APB_ADDR      12'h000
`define FLC_APB_WDATA     12'h004
`define FLC_APB_CMD       12'h008
`define FLC_APB_STATUS    12'h00C
`define FLC_APB_RDATA     12'h010
`endif

// file: flc_pkg.sv
/*
 Types shared by the two ends of the flash control block.
 Assumes flc_consts.svh is on the include path.
*/
package flc_pkg;
   `include "flc_consts.svh"

   typedef enum logic [1:0] {
      FLC_IDLE = 2'b01,
      FLC_WAIT = 2'b10
   } flc_host_st_e;

   typedef struct packed {
      logic        blk;
      logic        write_enable_bit;
      logic        mass_erase_bit;
      logic        erase;
      logic [1:0]  clk_src;
      logic [5:0]  clk_div;
      logic        emergency_exit_bit;
      logic        lock;
      logic        accv;
      logic        key_violation_flag;
      logic [7:0]  interrupt_enable_one;
      logic        ack;
      logic [15:0] rdata;
      logic        power_up_clear_reset;
      logic        nmi;
      logic        abort;
      logic        blk_end;
      logic        blk_on;
      logic        write_on;
      logic [1:0]  erase_type;
      logic [2:0]  clk_sel;
      logic [6:0]  divisor;
   } flc_dev_s;

   typedef struct packed {
      flc_host_st_e st;
      logic [15:0]  addr;
      logic [15:0]  wdata;
      logic [15:0]  rdata;
      logic         done;
      logic         req;
      logic         we;
      logic         mem;
      logic         pready;
      logic [31:0]  prdata;
   } flc_host_s;
endpackage

// file: flc_if.sv
/*
 Word access link between the processor-side end and the flash control registers.
 Assumes both ends share one clock; req is a one-cycle pulse, ack follows one cycle later.
*/
`timescale 1ns/1ps
interface flc_if;
   logic        req;   // One-cycle access request.
   logic        we;    // High for a write.
   logic        mem;   // High for a flash location, low for a register.
   logic [15:0] addr;  // Byte address.
   logic [15:0] wdata; // Write word.
   logic        ack;   // One-cycle answer.
   logic [15:0] rdata; // Read word, valid with ack.

   modport dev  (input req, we, mem, addr, wdata, output ack, rdata);
   modport host (output req, we, mem, addr, wdata, input ack, rdata);
endinterface

// file: flc_dev.sv
/*
 Flash controller control and status registers with key checking and violation flags.
 Assumes a timing generator on the same clock supplies busy and wait levels.
*/
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_dev
   import flc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   // Register and flash access link.
   flc_if.dev              bus,
   // Timing generator status.
   input  wire logic       busy_i,
   input  wire logic       wait_i,
   // Mode and clock outputs.
   output logic            blk_on_o,
   output logic            write_on_o,
   output logic [1:0]      erase_type_o,
   output logic            lock_o,
   output logic [2:0]      clk_sel_o,
   output logic [6:0]      divisor_o,
   // Events and requests.
   output logic            abort_o,
   output logic            blk_end_o,
   output logic            power_up_clear_reset_o,
   output logic            nmi_o
);
   flc_dev_s q;
   flc_dev_s next_q;
   logic     wr_reg;
   logic     key_ok;
   logic     accv_set;
   logic     mode_busy;
   logic     is_ctl;

   // Decode, key check, violations and register update.
   always_comb
   begin
      next_q = q;
      next_q.ack = 1'b0;
      next_q.power_up_clear_reset = 1'b0;
      next_q.abort = 1'b0;
      next_q.blk_end = 1'b0;
      accv_set = 1'b0;
      wr_reg = bus.req & bus.we & ~bus.mem;
      key_ok = (bus.wdata[15:8] == `FLC_KEY_WRITE);
      // A block write that waits for its next word is the only busy time that allows flash accesses and mode register writes.
      mode_busy = busy_i & ~(q.blk & wait_i);
      is_ctl = (bus.addr == `FLC_ADDR_MODE) | (bus.addr == `FLC_ADDR_CLOCK) | (bus.addr == `FLC_ADDR_STATUS);
      // Flash location accesses while unsafe.
      if (bus.req & bus.mem)
      begin
         if (bus.we & ~q.write_enable_bit)
         begin
            accv_set = 1'b1;
         end
         else if (mode_busy)
         begin
            accv_set = 1'b1;
         end
      end
      // A wrong key drops the write and asks for a system reset; the interrupt enable needs no key.
      if (wr_reg & is_ctl & ~key_ok)
      begin
         next_q.key_violation_flag = 1'b1;
         next_q.power_up_clear_reset = 1'b1;
      end
      else if (wr_reg)
      begin
         case (bus.addr)
            `FLC_ADDR_MODE:
            begin
               if (mode_busy)
               begin
                  accv_set = 1'b1;
               end
               else
               begin
                  next_q.blk = bus.wdata[`FLC_B_BLK];
                  next_q.write_enable_bit = bus.wdata[`FLC_B_WRITE_EN];
                  next_q.mass_erase_bit = bus.wdata[`FLC_B_MASS_ERASE];
                  next_q.erase = bus.wdata[`FLC_B_ERASE];
               end
            end
            `FLC_ADDR_CLOCK:
            begin
               if (busy_i)
               begin
                  accv_set = 1'b1;
               end
               else
               begin
                  next_q.clk_src = bus.wdata[7:6];
                  next_q.clk_div = bus.wdata[5:0];
               end
            end
            `FLC_ADDR_STATUS:
            begin
               // Busy and wait are timing generator levels and ignore the written value.
               next_q.emergency_exit_bit = bus.wdata[`FLC_B_EXIT];
               // Lock only gates new operations; a running write or erase is left alone.
               next_q.lock = bus.wdata[`FLC_B_LOCK];
               next_q.accv = bus.wdata[`FLC_B_ACCV];
               next_q.key_violation_flag = bus.wdata[`FLC_B_KEY_FLAG];
            end
            `FLC_ADDR_IRQ_EN:
            begin
               next_q.interrupt_enable_one = bus.wdata[7:0];
            end
            default:
            begin
               next_q.interrupt_enable_one = q.interrupt_enable_one;
            end
         endcase
      end
      // A new violation wins over a clear in the same cycle.
      next_q.accv = next_q.accv | accv_set;
      // Lock raised while a block write waits ends block mode; other operations run on.
      if (next_q.lock & ~q.lock & q.blk & wait_i)
      begin
         next_q.blk = 1'b0;
         next_q.blk_end = 1'b1;
      end
      // Emergency exit clears the mode bits and stops the timing generator.
      if (next_q.emergency_exit_bit)
      begin
         next_q.blk = 1'b0;
         next_q.write_enable_bit = 1'b0;
         next_q.mass_erase_bit = 1'b0;
         next_q.erase = 1'b0;
         // The abort pulse marks only the rise, so a held exit stops the generator once.
         next_q.abort = ~q.emergency_exit_bit;
      end
      // Read answer.
      if (bus.req)
      begin
         next_q.ack = 1'b1;
         if (bus.mem)
         begin
            // Flash reads during an operation see the loop opcode that parks the processor.
            next_q.rdata = busy_i ? `FLC_LOOP_OPCODE : 16'h0000;
         end
         else
         begin
            case (bus.addr)
               `FLC_ADDR_MODE:
                  next_q.rdata = {`FLC_KEY_READ, q.blk, q.write_enable_bit, 3'b000,
                                  q.mass_erase_bit, q.erase, 1'b0};
               `FLC_ADDR_CLOCK:
                  next_q.rdata = {`FLC_KEY_READ, q.clk_src, q.clk_div};
               `FLC_ADDR_STATUS:
                  next_q.rdata = {`FLC_KEY_READ, 2'b00, q.emergency_exit_bit, q.lock, wait_i, q.accv,
                                  q.key_violation_flag, busy_i};
               `FLC_ADDR_IRQ_EN:
                  next_q.rdata = {8'h00, q.interrupt_enable_one};
               default:
                  next_q.rdata = 16'h0000;
            endcase
         end
      end
      // Derived outputs.
      next_q.blk_on = next_q.blk & next_q.write_enable_bit;
      next_q.write_on = next_q.write_enable_bit;
      next_q.erase_type = {next_q.mass_erase_bit, next_q.erase};
      // Both upper source codes pick the sub-main clock.
      case (next_q.clk_src)
         2'b00:   next_q.clk_sel = 3'b001;
         2'b01:   next_q.clk_sel = 3'b010;
         default: next_q.clk_sel = 3'b100;
      endcase
      // The divisor reaches 64, so it needs one bit more than the field.
      next_q.divisor = {1'b0, next_q.clk_div} + 7'h01;
      next_q.nmi = next_q.accv & next_q.interrupt_enable_one[`FLC_B_ACCV_IRQ_EN];
   end

   // State register with reset values.
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         q <= '0;
         q.clk_src <= 2'b01;
         q.clk_div <= 6'h02;
         q.clk_sel <= 3'b010;
         q.divisor <= 7'h03;
         q.lock <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register.
   assign bus.ack = q.ack;
   assign bus.rdata = q.rdata;
   assign blk_on_o = q.blk_on;
   assign write_on_o = q.write_on;
   assign erase_type_o = q.erase_type;
   assign lock_o = q.lock;
   assign clk_sel_o = q.clk_sel;
   assign divisor_o = q.divisor;
   assign abort_o = q.abort;
   assign blk_end_o = q.blk_end;
   assign power_up_clear_reset_o = q.power_up_clear_reset;
   assign nmi_o = q.nmi;
endmodule

// file: flc_host.sv
/*
 Processor-side end: an APB slave whose command register issues one link access.
 Assumes the flash control end answers every request with one ack pulse.
*/
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_host
   import flc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // APB slave.
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   // Link to the flash control end.
   flc_if.host              bus
);
   flc_host_s q;
   flc_host_s next_q;
   logic      commit;

   // APB decode and link sequencing.
   always_comb
   begin
      next_q = q;
      next_q.req = 1'b0;
      commit = psel_i & penable_i & ~q.pready;
      next_q.pready = commit;
      if (commit & pwrite_i)
      begin
         case (paddr_i)
            `FLC_APB_ADDR:  next_q.addr = pwdata_i[15:0];
            `FLC_APB_WDATA: next_q.wdata = pwdata_i[15:0];
            `FLC_APB_CMD:
            begin
               if (q.st == FLC_IDLE)
               begin
                  next_q.we = pwdata_i[0];
                  next_q.mem = pwdata_i[1];
                  next_q.req = 1'b1;
                  next_q.done = 1'b0;
                  next_q.st = FLC_WAIT;
               end
            end
            default: next_q.addr = q.addr;
         endcase
      end
      if (commit)
      begin
         case (paddr_i)
            `FLC_APB_ADDR:   next_q.prdata = {16'h0000, q.addr};
            `FLC_APB_WDATA:  next_q.prdata = {16'h0000, q.wdata};
            `FLC_APB_CMD:    next_q.prdata = {30'h0000_0000, q.mem, q.we};
            `FLC_APB_STATUS: next_q.prdata = {30'h0000_0000, q.done, q.st == FLC_WAIT};
            `FLC_APB_RDATA:  next_q.prdata = {16'h0000, q.rdata};
            default:         next_q.prdata = 32'h0000_0000;
         endcase
      end
      case (q.st)
         FLC_IDLE: next_q.st = next_q.st;
         FLC_WAIT:
         begin
            if (bus.ack)
            begin
               next_q.rdata = bus.rdata;
               next_q.done = 1'b1;
               next_q.st = FLC_IDLE;
            end
         end
         default: next_q.st = FLC_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         q <= '0;
         q.st <= FLC_IDLE;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register; pslverr_o is tied low.
   assign pready_o = q.pready;
   assign prdata_o = q.prdata;
   assign pslverr_o = 1'b0;
   assign bus.req = q.req;
   assign bus.we = q.we;
   assign bus.mem = q.mem;
   assign bus.addr = q.addr;
   assign bus.wdata = q.wdata;
endmodule

// file: flc_properties.sv
/*
 Checker for the link between the two ends of the flash control block.
 Assumes one clock and an active-high synchronous reset.
*/
`timescale 1ns/1ps
module flc_properties (
   // Clock and reset.
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // Link and device signals.
   input  wire logic        req, we, mem, ack, busy_i, wait_i, power_up_clear_reset,
   input  wire logic [15:0] addr, wdata, rdata
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // Decoded control register reads and wrong-key writes.
   wire ctl     = !mem && (addr == 16'h0128 || addr == 16'h012A || addr == 16'h012C);
   wire rd_c    = req && !we && ctl;
   wire rd_mode = rd_c && addr == 16'h0128;
   wire rd_stat = rd_c && addr == 16'h012C;
   wire bad     = req && we && ctl && wdata[15:8] != 8'hA5;
   a_ack_follows: assert property (req |=> ack)
      else $error("Request not answered next cycle.");
   a_ack_cause: assert property (ack |-> $past(req))
      else $error("Answer without request.");
   a_key_readback: assert property (ack && $past(rd_c) |-> rdata[15:8] == 8'h96)
      else $error("Upper byte not 96h.");
   a_bad_key_reset: assert property (bad |=> power_up_clear_reset)
      else $error("Wrong key gave no reset request.");
   a_reset_cause: assert property (power_up_clear_reset |-> $past(bad))
      else $error("Reset request without wrong key.");
   a_mode_reserved: assert property (ack && $past(rd_mode) |-> rdata[5:3] == 3'h0 && !rdata[0])
      else $error("Mode reserved bits not zero.");
   a_stat_reserved: assert property (ack && $past(rd_stat) |-> rdata[7:6] == 2'h0)
      else $error("Status reserved bits not zero.");
   a_stat_levels: assert property (ack && $past(rd_stat) |-> rdata[3] == $past(wait_i) && rdata[0] == $past(busy_i))
      else $error("Wait or busy bit wrong.");
endmodule

// file: testbench.sv
/*
 Bench for the flash control block: APB into the host end, link to the device end.
 Assumes both ends share clock_i; busy and wait levels come from this bench.
*/
`timescale 1ns/1ps
module testbench;
   logic        clock_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, busy = 0, wt = 1;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000, prdata;
   logic        pready, blk_on, write_on, lock, abort, blk_end, clear_req, nmi;
   logic [1:0]  etype;
   logic [2:0]  csel;
   logic [6:0]  dvs;
   logic [15:0] r;
   int          err_count = 0, num_checks = 0, d;
   int          n_abort = 0, n_blk_end = 0;
   flc_if lnk ();
   flc_dev i_flc_dev (.clock_i, .srst_i, .bus(lnk), .busy_i(busy), .wait_i(wt), .blk_on_o(blk_on),
      .write_on_o(write_on), .erase_type_o(etype), .lock_o(lock), .clk_sel_o(csel), .divisor_o(dvs),
      .abort_o(abort), .blk_end_o(blk_end), .power_up_clear_reset_o(clear_req), .nmi_o(nmi));
   flc_host i_flc_host (.clock_i, .srst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(), .bus(lnk));
   flc_properties i_flc_properties (.clock_i, .srst_i, .req(lnk.req), .we(lnk.we), .mem(lnk.mem),
      .ack(lnk.ack), .busy_i(busy), .wait_i(wt), .power_up_clear_reset(clear_req), .addr(lnk.addr), .wdata(lnk.wdata),
      .rdata(lnk.rdata));
   // Clock of 10 ns period.
   always #5 clock_i = ~clock_i;
   // Counts the one-cycle event pulses of the device end.
   always @(posedge clock_i)
   begin
      if (abort === 1'b1)
         n_abort++;
      if (blk_end === 1'b1)
         n_blk_end++;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; read data lands in r; a hung slave ends the run.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] dat);
      int n;
      psel <= 1;
      pwr <= wr;
      paddr <= a;
      pwdata <= {16'h0000, dat};
      @(posedge clock_i);
      pen <= 1;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      r = prdata[15:0];
      psel <= 0;
      pen <= 0;
      @(posedge clock_i);
      if (n >= 50)
      begin
         err_count++;
         $display("ERROR %0t APB timeout", $time);
         tally_and_finish();
      end
   endtask
   // One link access through the host command register; r ends with the read word.
   task automatic acc(input logic wr, input logic mem, input logic [15:0] a, input logic [15:0] dat);
      int n;
      apb(1, 12'h000, a);
      apb(1, 12'h004, dat);
      apb(1, 12'h008, {14'h0000, mem, wr});
      n = 0;
      do
      begin
         apb(0, 12'h00C, 16'h0000);
         n++;
      end
      while (r[1:0] !== 2'h2 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         $display("ERROR %0t link timeout", $time);
         tally_and_finish();
      end
      apb(0, 12'h010, 16'h0000);
   endtask
   // Main sequence of tests.
   initial
   begin
      repeat (8) @(posedge clock_i);
      srst_i <= 0;
      @(posedge clock_i);
      acc(0, 0, 16'h0128, 0); chk(r, 16'h9600);
      acc(0, 0, 16'h012A, 0); chk(r, 16'h9642);
      acc(0, 0, 16'h012C, 0); chk(r, 16'h9618);
      $display("Test reset values done");
      acc(1, 0, 16'h0128, 16'hA5FF);
      acc(0, 0, 16'h0128, 0); chk(r, 16'h96C6);
      chk(blk_on, 1);
      acc(1, 0, 16'h0128, 16'hA580);
      chk(blk_on, 0);
      for (int i = 0; i < 4; i++)
      begin
         d = 21 * i;
         acc(1, 0, 16'h0128, {8'hA5, 5'h00, i[1:0], 1'h0});
         chk(etype, i[1:0]);
         acc(1, 0, 16'h012A, {8'hA5, i[1:0], d[5:0]});
         chk(csel, i == 0 ? 3'h1 : (i == 1 ? 3'h2 : 3'h4));
         chk(dvs, d + 1);
      end
      $display("Test mode and clock fields done");
      acc(1, 0, 16'h0128, 16'hA5C6);
      acc(1, 0, 16'h012C, 16'hA520);
      acc(0, 0, 16'h0128, 0); chk(r, 16'h9600);
      chk(write_on, 0);
      chk(n_abort, 1);
      acc(1, 0, 16'h012C, 16'hA500);
      chk(lock, 0);
      acc(1, 0, 16'h0128, 16'hA5C0);
      busy <= 1;
      acc(1, 0, 16'h012C, 16'hA510);
      chk(blk_on, 0);
      chk(n_blk_end, 1);
      $display("Test exit and block end done");
      wt <= 0;
      acc(1, 0, 16'h012A, 16'hA555);
      acc(0, 0, 16'h012A, 0); chk(r, 16'h96FF);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0005, 16'h0005);
      acc(1, 0, 16'h012C, 16'hA500);
      acc(0, 1, 16'hF000, 0); chk(r, 16'h3FFF);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0004, 16'h0004);
      acc(1, 0, 16'h012C, 16'hA510);
      chk(write_on, 1);
      chk(lock, 1);
      chk(n_abort, 1);
      chk(n_blk_end, 1);
      acc(1, 0, 16'h0128, 16'hA506);
      acc(0, 0, 16'h0128, 0); chk(r & 16'h0046, 16'h0040);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0004, 16'h0004);
      busy <= 0;
      wt <= 1;
      acc(1, 0, 16'h012C, 16'hA510);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0004, 16'h0000);
      acc(1, 0, 16'h0128, 16'hA500);
      acc(1, 1, 16'hF000, 16'h1234);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0004, 16'h0004);
      acc(1, 0, 16'h0000, 16'h0020);
      chk(nmi, 1);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0004, 16'h0004);
      acc(1, 0, 16'h012C, 16'hA510);
      chk(nmi, 0);
      $display("Test violations done");
      acc(1, 0, 16'h0128, 16'h1234);
      acc(0, 0, 16'h0128, 0); chk(r, 16'h9600);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0002, 16'h0002);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0002, 16'h0002);
      acc(1, 0, 16'h012C, 16'hA500);
      acc(0, 0, 16'h012C, 0); chk(r & 16'h0002, 16'h0000);
      $display("Test key violation done");
      tally_and_finish();
   end
endmodule
